// file: hw/acf_cfg.svh
`ifndef ACF_CFG_SVH
`define ACF_CFG_SVH
// Clock source codes.
`define ACF_CLK_INT_OFF    2'h0
`define ACF_CLK_INT_ON     2'h1
`define ACF_CLK_EXT_UNDIV  2'h2
`define ACF_CLK_EXT_DIV2   2'h3
// Filter word limits.
`define ACF_FW_MIN         11'h001
`define ACF_FW_SINC4_MAX   11'h00a
`define ACF_FW_SINC3_MAX   11'h7ff
`define ACF_FW_AVG3_MAX    11'h0cc
`define ACF_FW_REJ_BOTH    11'h030
// Averaging constants: sinc4 sum 4+8-1, sinc3 sum 3+8-1.
`define ACF_AVG_COUNT      4'h8
`define ACF_AVG4_MULT      4'hb
`define ACF_AVG3_MULT      4'ha
`define ACF_MCLK_PER_FW    6'h20
// Post filter periods in modulator-free master clocks (76800/rate).
`define ACF_POST1_PER      22'h000b80
`define ACF_POST2_PER      22'h000c80
`define ACF_POST3_PER      22'h000f80
`define ACF_POST4_PER      22'h001282
// Register indexes of the host-side port.
`define ACF_REG_CTRL       4'h0
`define ACF_REG_MISC       4'h1
`define ACF_REG_SETUP      4'h2
`define ACF_REG_CHAN       4'h3
`define ACF_REG_FILT       4'h4
`define ACF_REG_STAT       4'h5
`endif

// file: hw/acf_device.sv
`timescale 1ns/1ps
`include "acf_cfg.svh"
// Notes on behaviour
// - modulator rate is master clock halved.
// - internal oscillator selected after reset.
// - clock source code decoding, four options.
// - external clock 76.8 or 153.6 kHz.
// - interrupt routing overrides clock pin output.
// - sinc4 averaging period 32*word*11, word 1..10.
// - host keeps sinc3 averaging word at or below 0xcc.
// - word 48 gives 50 SPS dual rejection.
// - post filters ignore word, four rates.
// - bandgap off until enable bit set.
// - level bit picks 1.25 or 2.5 V.
// - reference source chosen per setup.
// - host sets holder bit when duty cycling.
// - host keeps reference on for sensors.
// - reference buffer enables per setup.
// - any pin as positive or negative.
// - five-bit positive and negative select fields.
// - mux changes only at conversion boundaries.
// - two currents, seven magnitudes each.
// - currents routed per channel, may share pin.
// - settle time waited before each conversion.
// - standby shutoff bit disables both currents while standby is set.
module acf_device (
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    acf_if.device           link,
    input  wire logic       int_tick_i,
    input  wire logic       irq_req_i,
    output logic            clk_pin_o,
    output logic            clk_pin_oe_o,
    output logic            mod_tick_o,
    output logic            bandgap_on_o,
    output logic            bandgap_low_o,
    output logic [1:0]      ref_select_o,
    output logic [1:0]      ref_buffer_en_o,
    output acf_pkg::acf_pin_t pos_pin_o,
    output acf_pkg::acf_pin_t neg_pin_o,
    output acf_pkg::acf_mag_t first_current_mag_o,
    output acf_pkg::acf_mag_t second_current_mag_o,
    output acf_pkg::acf_pin_t first_current_pin_o,
    output acf_pkg::acf_pin_t second_current_pin_o,
    output logic            holder_on_o,
    output logic            ref_keep_on_o,
    output logic [21:0]     conv_period_o
);
    import acf_pkg::*;
    // Sequencer state, tick counters and the latched selections.
    typedef enum logic [1:0] {ACF_IDLE, ACF_SETTLE, ACF_CONV} acf_state_t;
    acf_state_t  state_r, state_nxt;
    logic        mclk_tick, mod_tick, switched;
    logic [21:0] cnt_r;
    logic [7:0]  settle_r;
    logic [10:0] fw;
    logic [21:0] period;
    logic        tick_r;
    acf_pin_t    pos_r, neg_r, r0_r, r1_r;
    acf_mag_t    m0_r, m1_r;
    logic        clk_pin_r, clk_oe_r, done_r;

    // Master tick, modulator tick and source switch strobe.
    acf_mclk_gen u_acf_mclk_gen (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .src_i       (link.clk_source_sel),
        .int_tick_i  (int_tick_i),
        .ext_clk_i   (link.ext_clk),
        .mclk_tick_o (mclk_tick),
        .mod_tick_o  (mod_tick),
        .switched_o  (switched)
    );

    // Filter word clamped to the range of the chosen filter.
    wire [10:0] fw_raw  = link.filter_decimation_word;
    wire [10:0] fw_max  = (link.filter_type == ACF_SINC4 ||
                           link.filter_type == ACF_SINC4_AVG) ?
                          `ACF_FW_SINC4_MAX : `ACF_FW_SINC3_MAX;
    assign fw = (fw_raw < `ACF_FW_MIN) ? `ACF_FW_MIN :
                (fw_raw > fw_max) ? fw_max : fw_raw;
    wire [21:0] base  = 22'(fw) * 22'(`ACF_MCLK_PER_FW);
    wire [21:0] post_per =
        (link.post_select == 2'h0) ? `ACF_POST1_PER :
        (link.post_select == 2'h1) ? `ACF_POST2_PER :
        (link.post_select == 2'h2) ? `ACF_POST3_PER : `ACF_POST4_PER;
    wire [21:0] avg4_per = 22'(base * `ACF_AVG4_MULT);
    wire [21:0] avg3_per = 22'(base * `ACF_AVG3_MULT);
    // Conversion period in master clock ticks per filter type.
    always_comb begin
        unique case (link.filter_type)
            ACF_SINC4_AVG: period = avg4_per;
            ACF_SINC3_AVG: period = avg3_per;
            ACF_POST:      period = post_per;
            default:       period = base;
        endcase
    end

    // End of settling and of conversion, and the standby current cut.
    wire        stby_off   = link.standby & link.standby_current_shutoff;
    wire        conv_end   = (state_r == ACF_CONV) && mclk_tick &&
                             (cnt_r + 22'h1 >= period);
    wire        settle_end = (state_r == ACF_SETTLE) && mclk_tick &&
                             (settle_r >= link.frontend_settle_time);
    // Conversion sequencer: settle, convert, repeat; restart on switch.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ACF_IDLE:   if (!link.standby) state_nxt = ACF_SETTLE;
            ACF_SETTLE: if (settle_end) state_nxt = ACF_CONV;
            ACF_CONV:   if (conv_end) state_nxt = ACF_SETTLE;
        endcase
        if (switched || link.standby) state_nxt = ACF_IDLE;
    end

    // State register with tick counters for settling and conversion.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state_r  <= ACF_IDLE;
            cnt_r    <= 22'h0;
            settle_r <= 8'h0;
            done_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            done_r   <= conv_end;
            if (state_nxt != state_r) cnt_r <= 22'h0;
            else if (mclk_tick) cnt_r <= cnt_r + 22'h1;
            if (state_r != ACF_SETTLE) settle_r <= 8'h0;
            else if (mclk_tick) settle_r <= settle_r + 8'h1;
        end
    end

    // A conversion in flight keeps its inputs; changes wait for its end.
    wire        sel_open = (state_r != ACF_CONV);
    wire [2:0]  m0_nxt   = stby_off ? 3'h0 :
                           link.first_current_magnitude;
    wire [2:0]  m1_nxt   = stby_off ? 3'h0 :
                           link.second_current_magnitude;
    // Input and current pin selection latched only between conversions; magnitudes every cycle.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            pos_r <= 5'h0;
            neg_r <= 5'h0;
            r0_r  <= 5'h0;
            r1_r  <= 5'h0;
            m0_r  <= 3'h0;
            m1_r  <= 3'h0;
        end else begin
            if (sel_open) begin
                pos_r <= link.positive_input_select;
                neg_r <= link.negative_input_select;
                r0_r  <= link.first_current_pin_route;
                r1_r  <= link.second_current_pin_route;
            end
            m0_r <= m0_nxt;
            m1_r <= m1_nxt;
        end
    end

    // Clock pin: interrupt routing wins over the clock output choice.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            clk_pin_r <= 1'b0;
            clk_oe_r  <= 1'b0;
            tick_r    <= 1'b0;
        end else begin
            if (mclk_tick) tick_r <= ~tick_r;
            if (link.int_on_clk_pin) begin
                clk_oe_r  <= 1'b1;
                clk_pin_r <= irq_req_i;
            end else begin
                clk_oe_r  <= (link.clk_source_sel == `ACF_CLK_INT_ON);
                clk_pin_r <= tick_r;
            end
        end
    end

    // Handshake toward the host: a pulse per result, a level while active.
    assign link.conv_done   = done_r;
    assign link.busy        = (state_r != ACF_IDLE);
    assign clk_pin_o        = clk_pin_r;
    assign clk_pin_oe_o     = clk_oe_r;
    assign mod_tick_o       = mod_tick;

    // Reference controls follow the host settings directly.
    assign bandgap_on_o     = link.ref_enable;
    assign bandgap_low_o    = link.ref_enable &
                              link.bandgap_level_choice;
    assign ref_select_o     = link.ref_select;
    assign ref_buffer_en_o  = link.ref_buffer_en;

    // Selections and magnitudes come from the latched registers.
    assign pos_pin_o        = pos_r;
    assign neg_pin_o        = neg_r;
    assign first_current_mag_o  = m0_r;
    assign second_current_mag_o = m1_r;
    assign first_current_pin_o  = r0_r;
    assign second_current_pin_o = r1_r;

    // The reference core stays up while enabled and awake, or on request.
    assign holder_on_o      = link.standby_reference_holder_on;
    assign ref_keep_on_o    = link.standby_reference_keep_on |
                              (link.ref_enable & ~link.standby);
    assign conv_period_o    = period;
endmodule : acf_device

// file: hw/acf_host.sv
`timescale 1ns/1ps
`include "acf_cfg.svh"
// Host end: registers written by software drive the configuration.
module acf_host (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    acf_if.host              link,
    input  wire logic        ext_clk_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o
);
    import acf_pkg::*;
    logic [31:0] ctrl_r, misc_r, setup_r, chan_r, filt_r, rdata_r;
    logic [15:0] done_cnt_r;
    wire w_ctrl  = wr_i && addr_i == `ACF_REG_CTRL;
    wire w_misc  = wr_i && addr_i == `ACF_REG_MISC;
    wire w_setup = wr_i && addr_i == `ACF_REG_SETUP;
    wire w_chan  = wr_i && addr_i == `ACF_REG_CHAN;
    wire w_filt  = wr_i && addr_i == `ACF_REG_FILT;
    wire [31:0] stat = {15'h0, link.busy, done_cnt_r};
    // Host limits the sinc3 averaging word as recommended.
    wire [10:0] fw_w = filt_r[10:0];
    wire [10:0] fw_lim = (filt_r[18:16] == 3'(ACF_SINC3_AVG) &&
                          fw_w > `ACF_FW_AVG3_MAX) ?
                         `ACF_FW_AVG3_MAX : fw_w;
    wire [31:0] rd_mux =
        (addr_i == `ACF_REG_CTRL)  ? ctrl_r :
        (addr_i == `ACF_REG_MISC)  ? misc_r :
        (addr_i == `ACF_REG_SETUP) ? setup_r :
        (addr_i == `ACF_REG_CHAN)  ? chan_r :
        (addr_i == `ACF_REG_FILT)  ? filt_r :
        (addr_i == `ACF_REG_STAT)  ? stat : 32'h0;
    // Register writes, read data and completion counter.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ctrl_r     <= 32'h0;
            misc_r     <= 32'h0;
            setup_r    <= 32'h0;
            chan_r     <= 32'h0;
            filt_r     <= 32'h0;
            rdata_r    <= 32'h0;
            done_cnt_r <= 16'h0;
        end else begin
            if (w_ctrl)  ctrl_r  <= wdata_i;
            if (w_misc)  misc_r  <= wdata_i;
            if (w_setup) setup_r <= wdata_i;
            if (w_chan)  chan_r  <= wdata_i;
            if (w_filt)  filt_r  <= wdata_i;
            rdata_r <= rd_i ? rd_mux : 32'h0;
            if (link.conv_done) done_cnt_r <= done_cnt_r + 16'h1;
        end
    end
    assign rdata_o = rdata_r;
    assign link.clk_source_sel              = ctrl_r[1:0];
    assign link.ref_enable                  = ctrl_r[2];
    assign link.bandgap_level_choice        = ctrl_r[3];
    assign link.int_on_clk_pin              = ctrl_r[4];
    assign link.standby                     = ctrl_r[5];
    assign link.standby_reference_holder_on = misc_r[0];
    assign link.standby_reference_keep_on   = misc_r[1];
    assign link.standby_current_shutoff     = misc_r[2];
    assign link.ref_select                  = setup_r[1:0];
    assign link.ref_buffer_en               = setup_r[3:2];
    assign link.first_current_magnitude     = setup_r[6:4];
    assign link.second_current_magnitude    = setup_r[10:8];
    assign link.positive_input_select       = chan_r[4:0];
    assign link.negative_input_select       = chan_r[12:8];
    assign link.first_current_pin_route     = chan_r[20:16];
    assign link.second_current_pin_route    = chan_r[28:24];
    assign link.filter_decimation_word      = fw_lim;
    assign link.filter_type = (filt_r[18:16] > 3'(ACF_POST)) ?
                              ACF_SINC3 : acf_filter_t'(filt_r[18:16]);
    assign link.post_select                 = filt_r[21:20];
    assign link.frontend_settle_time        = filt_r[31:24];
    assign link.ext_clk                     = ext_clk_i;
endmodule : acf_host

// file: hw/acf_if.sv
`timescale 1ns/1ps
interface acf_if;
    import acf_pkg::*;
    logic [1:0]  clk_source_sel;
    logic        int_on_clk_pin;
    logic        ref_enable;
    logic        bandgap_level_choice;
    logic        standby_reference_holder_on;
    logic        standby_reference_keep_on;
    logic        standby_current_shutoff;
    logic        standby;
    logic [1:0]  ref_select;
    logic [1:0]  ref_buffer_en;
    acf_filter_t filter_type;
    logic [10:0] filter_decimation_word;
    logic [1:0]  post_select;
    logic [7:0]  frontend_settle_time;
    acf_pin_t    positive_input_select;
    acf_pin_t    negative_input_select;
    acf_mag_t    first_current_magnitude;
    acf_mag_t    second_current_magnitude;
    acf_pin_t    first_current_pin_route;
    acf_pin_t    second_current_pin_route;
    logic        ext_clk;
    logic        conv_done;
    logic        busy;
    modport device (
        input  clk_source_sel, int_on_clk_pin, ref_enable,
        input  bandgap_level_choice, standby_reference_holder_on,
        input  standby_reference_keep_on, standby_current_shutoff,
        input  standby, ref_select, ref_buffer_en, filter_type,
        input  filter_decimation_word, post_select, frontend_settle_time,
        input  positive_input_select, negative_input_select,
        input  first_current_magnitude, second_current_magnitude,
        input  first_current_pin_route, second_current_pin_route, ext_clk,
        output conv_done, busy
    );
    modport host (
        output clk_source_sel, int_on_clk_pin, ref_enable,
        output bandgap_level_choice, standby_reference_holder_on,
        output standby_reference_keep_on, standby_current_shutoff,
        output standby, ref_select, ref_buffer_en, filter_type,
        output filter_decimation_word, post_select, frontend_settle_time,
        output positive_input_select, negative_input_select,
        output first_current_magnitude, second_current_magnitude,
        output first_current_pin_route, second_current_pin_route, ext_clk,
        input  conv_done, busy
    );
endinterface : acf_if

// file: hw/acf_mclk_gen.sv
`timescale 1ns/1ps
`include "acf_cfg.svh"
// Builds master and modulator clock enables from the chosen source.
module acf_mclk_gen (
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic [1:0] src_i,
    input  wire logic       int_tick_i,
    input  wire logic       ext_clk_i,
    output logic            mclk_tick_o,
    output logic            mod_tick_o,
    output logic            switched_o
);
    logic [2:0] ext_sync_r;
    logic       ext_lvl_r;
    logic       ext_half_r;
    logic       mod_half_r;
    logic [1:0] src_r;
    // The pin level counts only once the second and third stages agree.
    wire        ext_agree = (ext_sync_r[1] == ext_sync_r[2]);
    wire        ext_rise  = ext_agree & ext_sync_r[2] & ~ext_lvl_r;
    wire        is_ext   = src_r[1];
    wire        ext_tick = (src_r == `ACF_CLK_EXT_DIV2) ?
                           (ext_rise & ext_half_r) : ext_rise;
    // Source changes take effect only on a master tick edge boundary.
    wire        mclk_tick = is_ext ? ext_tick : int_tick_i;
    wire        change    = (src_i != src_r) & mclk_tick;
    // Synchroniser, dividers and glitch-free source register.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ext_sync_r <= 3'h0;
            ext_lvl_r  <= 1'b0;
            ext_half_r <= 1'b0;
            mod_half_r <= 1'b0;
            src_r      <= `ACF_CLK_INT_OFF;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], ext_clk_i};
            if (ext_agree) ext_lvl_r <= ext_sync_r[2];
            if (ext_rise) ext_half_r <= ~ext_half_r;
            if (change) begin
                src_r      <= src_i;
                mod_half_r <= 1'b0;
            end else if (mclk_tick) begin
                mod_half_r <= ~mod_half_r;
            end
        end
    end
    assign mclk_tick_o = mclk_tick & ~change;
    assign mod_tick_o  = mclk_tick & ~change & mod_half_r;
    assign switched_o  = change;
endmodule : acf_mclk_gen

// file: hw/acf_pkg.sv
package acf_pkg;
    typedef enum logic [2:0] {
        ACF_SINC4, ACF_SINC4_AVG, ACF_SINC3, ACF_SINC3_REJ,
        ACF_SINC3_AVG, ACF_POST
    } acf_filter_t;
    typedef logic [4:0] acf_pin_t;
    typedef logic [2:0] acf_mag_t;
endpackage : acf_pkg

// file: tb/acf_chk.sv
`timescale 1ns/1ps
// Checks sequencing and settings seen on the link between the two ends.
module acf_chk (
    input wire logic                 clk_sys_i,
    input wire logic                 resetn_i,
    input wire logic [1:0]           clk_source_sel,
    input wire logic                 ref_enable,
    input wire logic                 bandgap_level_choice,
    input wire logic                 standby,
    input wire acf_pkg::acf_filter_t filter_type,
    input wire logic [10:0]          filter_decimation_word,
    input wire logic                 conv_done,
    input wire logic                 busy
);
    import acf_pkg::*;

    // All checks share the system clock and its reset.
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    // Completion pulses come only from a conversion that ran its course.
    AST_DONE_PULSE: assert property (conv_done |=> !conv_done)
        else $error("conv_done held past one cycle");
    AST_DONE_RUN: assert property (conv_done |-> $past(busy, 8))
        else $error("conv_done without a running conversion");
    AST_DONE_GAP: assert property (conv_done |=> !conv_done [*8])
        else $error("conv_done pulses too close");
    AST_IDLE_QUIET: assert property (!busy |=> !conv_done)
        else $error("conv_done while idle");
    AST_STBY_IDLE: assert property (standby [*3] |-> !busy)
        else $error("sequencer active in standby");
    AST_SRC_RESTART: assert property (
        $changed(clk_source_sel[1]) |-> ##[1:200] !busy)
        else $error("no restart after clock source switch");
    AST_RST_DEFAULT: assert property (
        $rose(resetn_i) |-> clk_source_sel == 2'h0 && !ref_enable
        && !bandgap_level_choice)
        else $error("link settings not cleared by reset");
    AST_AVG3_WORD: assert property (
        filter_type == ACF_SINC3_AVG |-> filter_decimation_word <= 11'h0cc)
        else $error("averaging word above limit");

    // Main scenarios reached.
    cover property (conv_done);
    cover property (standby [*3]);
    cover property ($changed(clk_source_sel[1]));
endmodule : acf_chk

// file: tb/tb_adc_clock_filter_frontend_ctrl.sv
`timescale 1ns/1ps
`include "acf_cfg.svh"
// Drives the host register port and judges the device end.
module tb_adc_clock_filter_frontend_ctrl;
    import acf_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        ext_clk   = 1'b0;
    logic        int_tick  = 1'b0;
    logic        irq       = 1'b0;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic [3:0]  addr      = 4'h0;
    logic [31:0] wdata     = 32'h0;
    logic [31:0] rdata;
    logic        cpin, coe, mtick, bg_on, bg_low, hold, keep;
    logic [1:0]  rsel, rbuf;
    acf_pin_t    pos, neg, p0, p1;
    acf_mag_t    m0, m1;
    logic [21:0] per;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    int          tcnt        = 0;
    int          ext_half    = 80;
    acf_if       link_if ();

    // System clock of 4 ns; external master clock 160 ns, 80 ns if halved.
    always #2 clk_sys_i = ~clk_sys_i;
    always #(ext_half) ext_clk = ~ext_clk;

    // Internal master tick every ten cycles, and the run limit.
    always @(posedge clk_sys_i) begin
        tcnt     <= (tcnt == 9) ? 0 : tcnt + 1;
        int_tick <= (tcnt == 9);
        cycles   <= cycles + 1;
        if (cycles == 80000) begin
            miscompares++;
            stop_test();
        end
    end

    acf_host u_acf_host (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .link(link_if.host), .ext_clk_i(ext_clk), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
    acf_device u_acf_device (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .link(link_if.device), .int_tick_i(int_tick), .irq_req_i(irq),
        .clk_pin_o(cpin), .clk_pin_oe_o(coe), .mod_tick_o(mtick),
        .bandgap_on_o(bg_on), .bandgap_low_o(bg_low), .ref_select_o(rsel),
        .ref_buffer_en_o(rbuf), .pos_pin_o(pos), .neg_pin_o(neg),
        .first_current_mag_o(m0), .second_current_mag_o(m1),
        .first_current_pin_o(p0), .second_current_pin_o(p1),
        .holder_on_o(hold), .ref_keep_on_o(keep), .conv_period_o(per));
    acf_chk u_acf_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .clk_source_sel(link_if.clk_source_sel),
        .ref_enable(link_if.ref_enable),
        .bandgap_level_choice(link_if.bandgap_level_choice),
        .standby(link_if.standby), .filter_type(link_if.filter_type),
        .filter_decimation_word(link_if.filter_decimation_word),
        .conv_done(link_if.conv_done), .busy(link_if.busy));

    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // Register write, then one idle cycle so strobes never merge.
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys_i);
        wr    <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wreg

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys_i);
        rd   <= 1'b0;
        @(posedge clk_sys_i);
        chk("rdata", rdata, e);
    endtask : rchk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc

    // Cycles between two pulses of completion or modulator tick.
    task automatic gap(input bit done, output int p);
        for (int i = 0; i < 4000 &&
             (done ? link_if.conv_done : mtick) !== 1'b1; i++)
            @(posedge clk_sys_i);
        p = 0;
        do begin
            @(posedge clk_sys_i);
            p++;
        end while (p < 4000 && (done ? link_if.conv_done : mtick) !== 1'b1);
    endtask : gap

    task automatic t_reset();
        wreg(4'hf, 32'hffff_ffff);
        rchk(4'hf, 32'h0);
        rchk(`ACF_REG_CTRL, 32'h0);
        chk("clk_oe", coe, 1'b0);
        chk("bg_on", bg_on, 1'b0);
        rchk(`ACF_REG_STAT, 32'h0001_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_clk();
        int   p;
        logic b;
        int   exp_p[4] = '{20, 20, 80, 80};
        for (int s = 0; s < 4; s++) begin
            if (s == 3) ext_half = 40;
            wreg(`ACF_REG_CTRL, 32'(s));
            cyc(400);
            gap(1'b0, p);
            chk("mod_gap", p, exp_p[s]);
            chk("clk_oe", coe, s == 1);
            if (s == 1) begin
                b = cpin;
                cyc(10);
                chk("clk_pin", cpin, !b);
            end
        end
        wreg(`ACF_REG_CTRL, 32'h11);
        irq <= 1'b1;
        cyc(4);
        chk("clk_pin", cpin, 1'b1);
        chk("clk_oe", coe, 1'b1);
        irq <= 1'b0;
        cyc(4);
        chk("clk_pin", cpin, 1'b0);
        wreg(`ACF_REG_CTRL, 32'h0);
        $display("test clock done");
    endtask : t_clk

    task automatic t_cfg();
        for (int i = 0; i < 4; i++) begin
            wreg(`ACF_REG_CTRL, 32'(i << 2));
            wreg(`ACF_REG_MISC, 32'(i));
            chk("bg_on", bg_on, i[0]);
            chk("bg_low", bg_low, i == 3);
            chk("holder", hold, i[0]);
            chk("keep_on", keep, i != 0);
        end
        wreg(`ACF_REG_CTRL, 32'h20);
        wreg(`ACF_REG_MISC, 32'h0);
        wreg(`ACF_REG_SETUP, 32'h0000_0366);
        wreg(`ACF_REG_CHAN, 32'h0707_001f);
        cyc(20);
        chk("ref_sel", rsel, 2'h2);
        chk("ref_buf", rbuf, 2'h1);
        chk("inputs", {pos, neg}, 10'h3e0);
        chk("routes", {p0, p1}, 10'h0e7);
        chk("mags", {m0, m1}, 6'h33);
        wreg(`ACF_REG_MISC, 32'h4);
        cyc(4);
        chk("mags", {m0, m1}, 6'h00);
        wreg(`ACF_REG_CTRL, 32'h0);
        cyc(2);
        chk("mags", {m0, m1}, 6'h33);
        wreg(`ACF_REG_MISC, 32'h0);
        $display("test config done");
    endtask : t_cfg

    task automatic t_mux();
        int p;
        for (int s = 0; s < 2; s++) begin
            wreg(`ACF_REG_FILT, {8'(s * 5), 24'h1});
            gap(1'b1, p);
            gap(1'b1, p);
            chk("done_gap", p, 330 + s * 50);
        end
        cyc(90);
        wreg(`ACF_REG_CHAN, 32'h0707_0003);
        cyc(20);
        chk("pos", pos, 5'h1f);
        gap(1'b1, p);
        cyc(80);
        chk("pos", pos, 5'h03);
        $display("test mux done");
    endtask : t_mux

    task automatic t_filt();
        logic [31:0] fv[10] = '{32'h0, 32'h0001_000a, 32'h0001_03ff,
            32'h0003_0030, 32'h0004_07ff, 32'h0002_07ff, 32'h0005_0007,
            32'h0015_0064, 32'h0025_0007, 32'h0035_0007};
        logic [21:0] ev[10] = '{22'd32, 22'd3520, 22'd3520, 22'd1536,
            22'd65280, 22'd65504, `ACF_POST1_PER, `ACF_POST2_PER,
            `ACF_POST3_PER, `ACF_POST4_PER};
        for (int i = 0; i < 10; i++) begin
            wreg(`ACF_REG_FILT, fv[i]);
            chk("period", per, ev[i]);
        end
        wreg(`ACF_REG_FILT, 32'h1);
        $display("test filter done");
    endtask : t_filt

    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // Reset for four cycles, then the scenarios in turn.
    initial begin
        repeat (4) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        t_reset();
        t_clk();
        t_cfg();
        t_mux();
        t_filt();
        stop_test();
    end
endmodule : tb_adc_clock_filter_frontend_ctrl
